// ### src/sys_ctrl_regs.sv
// System-control register bank behind an APB slave port.
//
// Contract
// - Voltage detect 1, 2 and monitor 0 control survive partial resets.
// - Monitor 1 and 2 control bits 2 and 3 survive partial resets.
// - Voltage detect 2 resets to 00h or 20h depending on source and option.
// - Monitor 0 control resets to 00h or 41h depending on source and option.
// - Count source protect resets to 80h when the option init bit is 0.
// - The option byte ignores CPU writes; only the flash path changes it.
// - System clock control 0 and 1 reset to 68h and 20h.
// - Oscillation stop detect resets to 04h.
// - Watchdog control resets to 1Fh; refresh and start hold no value.
// - Both address-match registers are three bytes wide and clear to zero.
// - Monitor 1 control and voltage detect 1 reset to 08h, monitor 2 to 00h.
// - Oscillator trim 1, 6 and 7 load factory trim; trim 0 and 2 reset to 00h.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module sys_ctrl_regs (
  // Clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      SRST,
  // APB slave
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [17:0]               PADDR,
  input  wire logic [31:0]               PWDATA,
  input  wire logic [3:0]                PSTRB,
  output wire logic                      PREADY,
  output wire logic [31:0]               PRDATA,
  output wire logic                      PSLVERR,
  // Reset sources, option byte and factory trim
  input  wire sys_ctrl_pkg::rst_evt_type RESET_EVENT,
  input  wire logic [7:0]                OPTION_BYTE,
  input  wire sys_ctrl_pkg::trim_type    TRIM,
  // Register contents and watchdog strobes
  output wire sys_ctrl_pkg::reg_image_type REG_IMAGE,
  output wire logic                      WD_REFRESH_PULSE,
  output wire logic                      WD_START_PULSE,
  output wire logic [7:0]                WD_WRITE_DATA
);
  import sys_ctrl_pkg::*;

  function automatic logic [4:0] find_reg(input logic [17:0] addr);
    logic [4:0] hit;
    hit = IX_NONE;
    for (int k = 0; k < NREG; k++) begin
      if (addr[1:0] == 2'b00 && addr[17:2] == REG_OFFSET[k]) begin
        hit = 5'(k);
      end
    end
    return hit;
  endfunction

  function automatic logic is_partial(input rst_src_type src);
    return src inside {SRC_SOFTWARE, SRC_WATCHDOG, SRC_VMON1, SRC_VMON2};
  endfunction

  function automatic logic [7:0] reset_value(input int k, input rst_src_type src,
                                             input logic [7:0] opt, input trim_type trim);
    logic       quiet;
    logic [7:0] rv;
    quiet = (src == SRC_HARDWARE) && opt[LOW_VOLTAGE_DETECT_OFF_BIT];
    case (k)
      IX_CNT_SRC_PROT: rv = opt[COUNT_SOURCE_PROTECT_INITIAL_BIT] ? RST_ZERO
                                                                  : RST_CNT_SRC_PROT_ON;
      IX_VDET_2:       rv = quiet ? RST_VDET_2_QUIET : RST_VDET_2_ACTIVE;
      IX_VMON0:        rv = quiet ? RST_VMON0_QUIET : RST_VMON0_ACTIVE;
      IX_FAST_OSC_1:   rv = trim.fast_osc_1;
      IX_FAST_OSC_6:   rv = trim.fast_osc_6;
      IX_FAST_OSC_7:   rv = trim.fast_osc_7;
      IX_OPTION:       rv = opt;
      default:         rv = RST_VALUE[k];
    endcase
    return rv;
  endfunction

  function automatic logic [7:0] keep_mask(input int k);
    logic [7:0] km;
    case (k)
      IX_VDET_1, IX_VDET_2, IX_VMON0: km = KEEP_ALL_MASK;
      IX_VMON1, IX_VMON2:             km = VMON_KEEP_MASK;
      default:                        km = RST_ZERO;
    endcase
    return km;
  endfunction

  // Bus decode.
  wire logic [4:0]  sel_idx     = find_reg(PADDR);
  wire logic        sel_ok      = sel_idx != IX_NONE;
  wire logic        setup_phase = PSEL & ~PENABLE;
  wire logic        access      = PSEL & PENABLE;
  wire logic        wr_commit   = access & PWRITE & PSTRB[0];

  // Reset classes; the pin reset counts as a power-on reset.
  wire logic        full_rst    = SRST | (RESET_EVENT.req & ~is_partial(RESET_EVENT.src));
  wire logic        part_rst    = ~SRST & RESET_EVENT.req & is_partial(RESET_EVENT.src);
  wire rst_src_type rst_src     = SRST ? SRC_POWER_ON : RESET_EVENT.src;

  reg_image_type image_w;

  // A reset in the same cycle as a write wins, since the CPU is being reset with it.
  for (genvar k = 0; k < NREG; k++) begin : g_reg
    wire logic [7:0] rv = reset_value(k, rst_src, OPTION_BYTE, TRIM);
    wire logic [7:0] km = keep_mask(k);
    wire logic       we = wr_commit & (sel_idx == 5'(k)) & WRITABLE[k];
    logic [7:0]      val_q;
    always_ff @(posedge CLK_SYS) begin
      if (full_rst) begin
        val_q <= rv;
      end else if (part_rst) begin
        val_q <= (val_q & km) | (rv & ~km);
      end else if (k == IX_OPTION) begin
        val_q <= OPTION_BYTE;
      end else if (we) begin
        val_q <= PWDATA[7:0];
      end
    end
    assign image_w[k] = val_q;
  end

  assign REG_IMAGE = image_w;

  // Read data is fetched in the setup phase so the access phase needs no wait state.
  wire logic [7:0] rd_byte = (sel_ok && READABLE[sel_idx]) ? image_w[sel_idx] : 8'h00;

  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        wd_refresh_q;
  logic        wd_start_q;
  logic [7:0]  wd_data_q;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q  <= {24'h00_0000, rd_byte};
      pslverr_q <= ~sel_ok;
    end
  end

  // Refresh and start hold nothing; a write only sends a one-cycle strobe.
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      wd_refresh_q <= 1'b0;
      wd_start_q   <= 1'b0;
      wd_data_q    <= 8'h00;
    end else begin
      wd_refresh_q <= wr_commit & (sel_idx == 5'(IX_WD_REFRESH));
      wd_start_q   <= wr_commit & (sel_idx == 5'(IX_WD_START));
      if (wr_commit) begin
        wd_data_q <= PWDATA[7:0];
      end
    end
  end

  assign PREADY           = 1'b1;
  assign PRDATA           = prdata_q;
  assign PSLVERR          = pslverr_q;
  assign WD_REFRESH_PULSE = wd_refresh_q;
  assign WD_START_PULSE   = wd_start_q;
  assign WD_WRITE_DATA    = wd_data_q;

  // Checks.
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  sequence s_bad_setup;
    setup_phase && !sel_ok;
  endsequence

  sequence s_option_write;
    setup_phase && PWRITE && sel_idx == 5'(IX_OPTION) ##1 access;
  endsequence

  a_unmapped_error: assert property (s_bad_setup |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not answered with error");
  a_keep_vdet_regs: assert property (part_rst |=>
      image_w[IX_VDET_1] == $past(image_w[IX_VDET_1]) &&
      image_w[IX_VDET_2] == $past(image_w[IX_VDET_2]) &&
      image_w[IX_VMON0] == $past(image_w[IX_VMON0]))
    else $error("voltage registers changed on partial reset");
  a_keep_vmon_bits: assert property (part_rst |=>
      image_w[IX_VMON1][3:2] == $past(image_w[IX_VMON1][3:2]) &&
      image_w[IX_VMON2][3:2] == $past(image_w[IX_VMON2][3:2]) &&
      image_w[IX_VMON1][7:4] == 4'h0)
    else $error("monitor control bits 3:2 not kept");
  a_vdet2_quiet: assert property (RESET_EVENT.req && RESET_EVENT.src == SRC_HARDWARE &&
      OPTION_BYTE[LOW_VOLTAGE_DETECT_OFF_BIT] |=> image_w[IX_VDET_2] == 8'h00)
    else $error("voltage detect 2 wrong after hardware reset");
  a_vmon0_power_on: assert property ($fell(SRST) |-> image_w[IX_VMON0] == 8'h41)
    else $error("monitor 0 control wrong after power-on reset");
  a_csp_reset: assert property ($fell(SRST) |-> image_w[IX_CNT_SRC_PROT] ==
      ($past(OPTION_BYTE[COUNT_SOURCE_PROTECT_INITIAL_BIT]) ? 8'h00 : 8'h80))
    else $error("count source protect reset value wrong");
  a_option_read_only: assert property (s_option_write |=>
      image_w[IX_OPTION] == $past(OPTION_BYTE))
    else $error("option byte took a CPU write");
  a_clock_reset: assert property ($fell(SRST) |->
      image_w[IX_SYS_CLK_0] == 8'h68 && image_w[IX_SYS_CLK_1] == 8'h20)
    else $error("clock control reset value wrong");
  a_osc_stop_reset: assert property ($fell(SRST) |-> image_w[IX_OSC_STOP] == 8'h04)
    else $error("oscillation stop reset value wrong");
  a_wd_ctrl_reset: assert property ($fell(SRST) |-> image_w[IX_WD_CTRL] == 8'h1F &&
      !WD_REFRESH_PULSE && !WD_START_PULSE)
    else $error("watchdog control reset value wrong");
  a_amatch_clear: assert property ($fell(SRST) |->
      {image_w[IX_AMATCH_0 + 2], image_w[IX_AMATCH_0 + 1], image_w[IX_AMATCH_0]} == 24'h0 &&
      {image_w[IX_AMATCH_1 + 2], image_w[IX_AMATCH_1 + 1], image_w[IX_AMATCH_1]} == 24'h0)
    else $error("address match registers not cleared");
  a_vmon_reset: assert property ($fell(SRST) |-> image_w[IX_VMON1] == 8'h08 &&
      image_w[IX_VMON2] == 8'h00 && image_w[IX_VDET_1] == 8'h08)
    else $error("monitor reset values wrong");
  a_trim_load: assert property ($fell(SRST) |->
      image_w[IX_FAST_OSC_1] == $past(TRIM.fast_osc_1) &&
      image_w[IX_FAST_OSC_7] == $past(TRIM.fast_osc_7) && image_w[IX_FAST_OSC_0] == 8'h00)
    else $error("oscillator trim not loaded");
  a_byte_write: assert property (wr_commit && sel_idx == 5'(IX_PROC_MODE_0) &&
      !RESET_EVENT.req |=> image_w[IX_PROC_MODE_0] == $past(PWDATA[7:0]))
    else $error("byte write lost");
  a_byte_read: assert property (setup_phase && !PWRITE &&
      sel_idx == 5'(IX_PROC_MODE_0) |=>
      PRDATA == {24'h00_0000, $past(image_w[IX_PROC_MODE_0])})
    else $error("byte readback lost");

endmodule

// ### src/sys_ctrl_pkg.sv
// Package with the map, reset values and carrier types of the system-control register bank.
package sys_ctrl_pkg;

  localparam int NREG = 27;

  // Register indices; the APB byte address is four times the index.
  localparam logic [15:0] OFF_PROC_MODE_0  = 16'h0004;
  localparam logic [15:0] OFF_PROC_MODE_1  = 16'h0005;
  localparam logic [15:0] OFF_SYS_CLK_0    = 16'h0006;
  localparam logic [15:0] OFF_SYS_CLK_1    = 16'h0007;
  localparam logic [15:0] OFF_WRITE_PROT   = 16'h000A;
  localparam logic [15:0] OFF_OSC_STOP     = 16'h000C;
  localparam logic [15:0] OFF_WD_REFRESH   = 16'h000D;
  localparam logic [15:0] OFF_WD_START     = 16'h000E;
  localparam logic [15:0] OFF_WD_CTRL      = 16'h000F;
  localparam logic [15:0] OFF_AMATCH_0     = 16'h0010;
  localparam logic [15:0] OFF_AMATCH_1     = 16'h0014;
  localparam logic [15:0] OFF_CNT_SRC_PROT = 16'h001C;
  localparam logic [15:0] OFF_FAST_OSC_0   = 16'h0023;
  localparam logic [15:0] OFF_FAST_OSC_1   = 16'h0024;
  localparam logic [15:0] OFF_FAST_OSC_2   = 16'h0025;
  localparam logic [15:0] OFF_FAST_OSC_6   = 16'h002B;
  localparam logic [15:0] OFF_FAST_OSC_7   = 16'h002C;
  localparam logic [15:0] OFF_VDET_1       = 16'h0031;
  localparam logic [15:0] OFF_VDET_2       = 16'h0032;
  localparam logic [15:0] OFF_VMON1        = 16'h0036;
  localparam logic [15:0] OFF_VMON2        = 16'h0037;
  localparam logic [15:0] OFF_VMON0        = 16'h0038;
  localparam logic [15:0] OFF_OPTION       = 16'hFFFF;

  // Slots in the register image.
  localparam int IX_PROC_MODE_0  = 0;
  localparam int IX_SYS_CLK_0    = 2;
  localparam int IX_SYS_CLK_1    = 3;
  localparam int IX_OSC_STOP     = 5;
  localparam int IX_WD_REFRESH   = 6;
  localparam int IX_WD_START     = 7;
  localparam int IX_WD_CTRL      = 8;
  localparam int IX_AMATCH_0     = 9;
  localparam int IX_AMATCH_1     = 12;
  localparam int IX_CNT_SRC_PROT = 15;
  localparam int IX_FAST_OSC_0   = 16;
  localparam int IX_FAST_OSC_1   = 17;
  localparam int IX_FAST_OSC_6   = 19;
  localparam int IX_FAST_OSC_7   = 20;
  localparam int IX_VDET_1       = 21;
  localparam int IX_VDET_2       = 22;
  localparam int IX_VMON1        = 23;
  localparam int IX_VMON2        = 24;
  localparam int IX_VMON0        = 25;
  localparam int IX_OPTION       = 26;
  localparam logic [4:0] IX_NONE = 5'h1B;

  localparam logic [15:0] REG_OFFSET [NREG] = '{
    OFF_PROC_MODE_0, OFF_PROC_MODE_1, OFF_SYS_CLK_0, OFF_SYS_CLK_1, OFF_WRITE_PROT,
    OFF_OSC_STOP, OFF_WD_REFRESH, OFF_WD_START, OFF_WD_CTRL,
    OFF_AMATCH_0, OFF_AMATCH_0 + 16'h0001, OFF_AMATCH_0 + 16'h0002,
    OFF_AMATCH_1, OFF_AMATCH_1 + 16'h0001, OFF_AMATCH_1 + 16'h0002,
    OFF_CNT_SRC_PROT, OFF_FAST_OSC_0, OFF_FAST_OSC_1, OFF_FAST_OSC_2, OFF_FAST_OSC_6,
    OFF_FAST_OSC_7, OFF_VDET_1, OFF_VDET_2, OFF_VMON1, OFF_VMON2, OFF_VMON0, OFF_OPTION};

  // Fixed reset values; undefined bits come up as zero.
  localparam logic [7:0] RST_ZERO            = 8'h00;
  localparam logic [7:0] RST_SYS_CLK_0       = 8'h68;
  localparam logic [7:0] RST_SYS_CLK_1       = 8'h20;
  localparam logic [7:0] RST_OSC_STOP        = 8'h04;
  localparam logic [7:0] RST_WD_CTRL         = 8'h1F;
  localparam logic [7:0] RST_CNT_SRC_PROT_ON = 8'h80;
  localparam logic [7:0] RST_VDET_1          = 8'h08;
  localparam logic [7:0] RST_VDET_2_QUIET    = 8'h00;
  localparam logic [7:0] RST_VDET_2_ACTIVE   = 8'h20;
  localparam logic [7:0] RST_VMON1           = 8'h08;
  localparam logic [7:0] RST_VMON0_QUIET     = 8'h00;
  localparam logic [7:0] RST_VMON0_ACTIVE    = 8'h41;
  localparam logic [7:0] VMON_KEEP_MASK      = 8'h0C;
  localparam logic [7:0] KEEP_ALL_MASK       = 8'hFF;

  localparam logic [7:0] RST_VALUE [NREG] = '{
    RST_ZERO, RST_ZERO, RST_SYS_CLK_0, RST_SYS_CLK_1, RST_ZERO, RST_OSC_STOP, RST_ZERO,
    RST_ZERO, RST_WD_CTRL, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_VDET_1, RST_ZERO,
    RST_VMON1, RST_ZERO, RST_ZERO, RST_ZERO};

  // Bit k set: slot k takes CPU writes / returns its value on reads.
  // Refresh and start only strobe; trim 6/7, voltage detect 1 and the option byte are read-only.
  localparam logic [NREG-1:0] WRITABLE = 27'h3C7FF3F;
  localparam logic [NREG-1:0] READABLE = 27'h7FFFF3F;

  // Option byte fields.
  localparam int LOW_VOLTAGE_DETECT_OFF_BIT       = 5;
  localparam int COUNT_SOURCE_PROTECT_INITIAL_BIT = 7;

  typedef enum logic [2:0] {
    SRC_POWER_ON = 3'b000,
    SRC_HARDWARE = 3'b001,
    SRC_VMON0    = 3'b010,
    SRC_SOFTWARE = 3'b011,
    SRC_WATCHDOG = 3'b100,
    SRC_VMON1    = 3'b101,
    SRC_VMON2    = 3'b110
  } rst_src_type;

  typedef struct packed {
    logic        req;
    rst_src_type src;
  } rst_evt_type;

  typedef struct packed {
    logic [7:0] fast_osc_1;
    logic [7:0] fast_osc_6;
    logic [7:0] fast_osc_7;
  } trim_type;

  typedef logic [NREG-1:0][7:0] reg_image_type;

endpackage

// ### dv/apb_cpu_model.sv
// APB master model standing in for the CPU core on the peripheral bus.
`timescale 1ns/100ps
module apb_cpu_model (
  // Clock
  input  wire logic        clk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [17:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  // APB answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 18'h00000;
    pwdata  = 32'h00000000;
    pstrb   = 4'h0;
  end

  // The byte address is four times the register index.
  // Reserved indices are issued only when the bench wants the error answer.
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                      input logic [3:0] st, output logic [7:0] rd, output logic er);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    pstrb   <= st;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    // Released lines flip so that nothing can lean on stale address or data.
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~paddr;
    pwdata  <= ~pwdata;
  endtask
endmodule

// ### dv/test_sys_ctrl_regs.sv
// Self-checking bench for the system-control register bank.
`timescale 1ns/100ps
module test_sys_ctrl_regs;
  import sys_ctrl_pkg::*;

  localparam int LIMIT = 5000;

  logic          clk_sys;
  logic          srst;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [17:0]   paddr;
  logic [31:0]   pwdata;
  logic [3:0]    pstrb;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  rst_evt_type   rst_evt;
  logic [7:0]    option_byte;
  trim_type      trim;
  reg_image_type reg_image;
  logic          wd_refresh;
  logic          wd_start;
  logic [7:0]    wd_data;
  int            err_total;
  int            total_checks;
  int            cycles;

  sys_ctrl_regs u_sys_ctrl_regs (.CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .RESET_EVENT(rst_evt),
    .OPTION_BYTE(option_byte), .TRIM(trim), .REG_IMAGE(reg_image),
    .WD_REFRESH_PULSE(wd_refresh), .WD_START_PULSE(wd_start), .WD_WRITE_DATA(wd_data));

  apb_cpu_model u_apb_cpu_model (.clk(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

  always #4 clk_sys = ~clk_sys;

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A hang is cut short here and still ends in the one closing report.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xchk(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                      input logic [3:0] st, input logic [7:0] exp, input logic err);
    logic [7:0] rd;
    logic       er;
    u_apb_cpu_model.xfer(wr, idx, d, st, rd, er);
    if (!wr)
      check({24'h000000, rd}, {24'h000000, exp});
    check({31'h00000000, er}, {31'h00000000, err});
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    xchk(1'b0, idx, 8'h00, 4'h0, exp, 1'b0);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xchk(1'b1, idx, d, 4'h1, 8'h00, 1'b0);
  endtask

  task automatic fire_reset(input rst_src_type s, input logic [7:0] opt);
    @(posedge clk_sys);
    option_byte <= opt;
    rst_evt     <= '{1'b1, s};
    @(posedge clk_sys);
    rst_evt     <= '{1'b0, s};
  endtask

  task automatic test_reset_values;
    logic [15:0] ri [24] = '{OFF_PROC_MODE_0, OFF_PROC_MODE_1, OFF_SYS_CLK_0, OFF_SYS_CLK_1,
      OFF_WRITE_PROT, OFF_OSC_STOP, OFF_WD_CTRL, OFF_AMATCH_0, OFF_AMATCH_0 + 16'h0001,
      OFF_AMATCH_0 + 16'h0002, OFF_AMATCH_1, OFF_AMATCH_1 + 16'h0001, OFF_AMATCH_1 + 16'h0002,
      OFF_CNT_SRC_PROT, OFF_FAST_OSC_0, OFF_FAST_OSC_1, OFF_FAST_OSC_2, OFF_FAST_OSC_6,
      OFF_FAST_OSC_7, OFF_VDET_1, OFF_VDET_2, OFF_VMON1, OFF_VMON2, OFF_VMON0};
    logic [7:0] ev [24] = '{8'h00, 8'h00, 8'h68, 8'h20, 8'h00, 8'h04, 8'h1F, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, trim.fast_osc_1, 8'h00, trim.fast_osc_6,
      trim.fast_osc_7, 8'h08, 8'h20, 8'h08, 8'h00, 8'h41};
    for (int i = 0; i < 24; i++)
      rd_chk(ri[i], ev[i]);
  endtask

  task automatic test_option_ro;
    @(posedge clk_sys);
    option_byte <= 8'h5C;
    rd_chk(OFF_OPTION, 8'h5C);
    wr(OFF_OPTION, 8'hA3);
    rd_chk(OFF_OPTION, 8'h5C);
  endtask

  task automatic test_unmapped;
    xchk(1'b0, 16'h0001, 8'h00, 4'h0, 8'h00, 1'b1);
    xchk(1'b1, 16'h0008, 8'hFF, 4'h1, 8'h00, 1'b1);
    rd_chk(OFF_PROC_MODE_0, 8'h00);
  endtask

  task automatic test_partial_reset;
    rst_src_type srcs [4] = '{SRC_SOFTWARE, SRC_WATCHDOG, SRC_VMON1, SRC_VMON2};
    wr(OFF_VDET_2, 8'h5A);
    wr(OFF_VMON0, 8'h3C);
    foreach (srcs[i]) begin
      wr(OFF_VMON1, 8'hF7);
      wr(OFF_VMON2, 8'hF7);
      wr(OFF_PROC_MODE_0, 8'h77);
      fire_reset(srcs[i], 8'h00);
      rd_chk(OFF_VDET_2, 8'h5A);
      rd_chk(OFF_VMON0, 8'h3C);
      rd_chk(OFF_VDET_1, 8'h08);
      rd_chk(OFF_VMON1, 8'h04);
      rd_chk(OFF_VMON2, 8'h04);
      rd_chk(OFF_PROC_MODE_0, 8'h00);
    end
  endtask

  task automatic test_full_reset;
    fire_reset(SRC_HARDWARE, 8'h20);
    rd_chk(OFF_VDET_2, 8'h00);
    rd_chk(OFF_VMON0, 8'h00);
    rd_chk(OFF_CNT_SRC_PROT, 8'h80);
    rd_chk(OFF_VMON1, 8'h08);
    fire_reset(SRC_HARDWARE, 8'hA0);
    rd_chk(OFF_CNT_SRC_PROT, 8'h00);
    fire_reset(SRC_VMON0, 8'hA0);
    rd_chk(OFF_VDET_2, 8'h20);
    rd_chk(OFF_VMON0, 8'h41);
    fire_reset(SRC_HARDWARE, 8'h00);
    rd_chk(OFF_VDET_2, 8'h20);
    rd_chk(OFF_VMON0, 8'h41);
  endtask

  task automatic test_rw_bytes;
    logic [7:0] d [3] = '{8'h11, 8'h22, 8'h33};
    for (int i = 0; i < 3; i++) begin
      wr(OFF_AMATCH_0 + 16'(i), d[i]);
      wr(OFF_AMATCH_1 + 16'(i), ~d[i]);
    end
    for (int i = 0; i < 3; i++) begin
      rd_chk(OFF_AMATCH_0 + 16'(i), d[i]);
      rd_chk(OFF_AMATCH_1 + 16'(i), ~d[i]);
    end
    check({24'h000000, reg_image[IX_AMATCH_0]}, 32'h00000011);
    check({24'h000000, reg_image[IX_AMATCH_0 + 2]}, 32'h00000033);
    wr(OFF_WD_CTRL, 8'hA5);
    rd_chk(OFF_WD_CTRL, 8'hA5);
    xchk(1'b1, OFF_PROC_MODE_0, 8'hEE, 4'h0, 8'h00, 1'b0);
    rd_chk(OFF_PROC_MODE_0, 8'h00);
  endtask

  // The strobe stands for the one cycle after the commit edge; look at it mid-cycle.
  task automatic test_wd_strobes;
    wr(OFF_WD_REFRESH, 8'h5A);
    @(negedge clk_sys);
    check({31'h00000000, wd_refresh}, 32'h00000001);
    check({31'h00000000, wd_start}, 32'h00000000);
    check({24'h000000, wd_data}, 32'h0000005A);
    @(negedge clk_sys);
    check({31'h00000000, wd_refresh}, 32'h00000000);
    wr(OFF_WD_START, 8'hC6);
    @(negedge clk_sys);
    check({31'h00000000, wd_start}, 32'h00000001);
    check({31'h00000000, wd_refresh}, 32'h00000000);
    check({24'h000000, wd_data}, 32'h000000C6);
    @(negedge clk_sys);
    check({31'h00000000, wd_start}, 32'h00000000);
    rd_chk(OFF_WD_REFRESH, 8'h00);
    rd_chk(OFF_WD_START, 8'h00);
  endtask

  initial begin
    clk_sys      = 1'b0;
    srst         = 1'b1;
    rst_evt      = '0;
    option_byte  = 8'h00;
    trim         = '{8'hA5, 8'h3C, 8'hC3};
    err_total    = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    test_reset_values();
    test_option_ro();
    test_unmapped();
    test_partial_reset();
    test_full_reset();
    test_rw_bytes();
    test_wd_strobes();
    give_verdict();
  end
endmodule
